// ### rtl/ecs_pkg.sv
// Purpose: Shared constants and carrier types of the exception control and state block
// Assumes: 32-bit AXI4-Lite register bus, word-aligned registers
// Notes:   Offsets are byte addresses
package ecs_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;

  // ----------------------------------------------------------------
  // Control and state register fields
  // ----------------------------------------------------------------
  localparam int SVC_SET_BIT  = 28;
  localparam int SVC_CLR_BIT  = 27;
  localparam int TICK_SET_BIT = 26;
  localparam int TICK_CLR_BIT = 25;
  localparam int ANY_PEND_BIT = 22;
  localparam int HIGH_LSB     = 12;
  localparam int ACT_LSB      = 0;
  localparam int NUM_W        = 6;
  localparam int CMD_LANE     = 3;

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  localparam int         N_EVT     = 3;
  localparam int         EVT_SVC   = 0;
  localparam int         EVT_TICK  = 1;
  localparam int         EVT_ANY   = 2;
  localparam logic [2:0] MASK_RST  = 3'h0;

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // State reported by the core and its prioritiser
  typedef struct packed {
    logic       any_interrupt_pending;
    logic       highest_valid;
    logic [5:0] highest_pending_number;
    logic [8:0] program_status_exception_field;
  } ecs_core_t;

  // Hardware requests on the pending flags
  typedef struct packed {
    logic tick_event;
    logic service_call_taken;
    logic tick_taken;
  } ecs_hw_t;

endpackage

// ### rtl/ecs_pend_bit.sv
// Purpose: One pending flag with set and clear requests
// Assumes: Synchronous active-high reset
// Notes:   A set in the same cycle as a clear wins
`timescale 1ns/100ps
module ecs_pend_bit (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Requests
  input  wire logic set_i,
  input  wire logic clr_i,
  // State
  output logic      pend_o
);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      pend_o <= 1'b0;
    end
    else
    begin
      pend_o <= set_i | (pend_o & ~clr_i);
    end
  end

endmodule

// ### rtl/ecs_irq_status.sv
// Purpose: Sticky event status, mask gating and the level interrupt
// Assumes: Synchronous active-high reset
// Notes:   Set wins over read-clear; interrupt lags status by one cycle
`timescale 1ns/100ps
module ecs_irq_status #(
  parameter int N = 3
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Events and clearing
  input  wire logic [N-1:0] set_i,
  input  wire logic [N-1:0] clr_i,
  input  wire logic [N-1:0] mask_i,
  // Outputs
  output logic      [N-1:0] status_o,
  output logic              irq_o
);

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      status_o <= '0;
    end
    else
    begin
      status_o <= set_i | (status_o & ~clr_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= |(status_o & mask_i);
    end
  end

endmodule

// ### rtl/ecs_top.sv
// Purpose: Exception control and state register with AXI4-Lite access
// Assumes: One 10 MHz clock, synchronous active-high reset, core inputs synchronous
// Notes:   Prioritisation lives outside; its results arrive on CORE_I
//
// Contract
// - Only software write sets service-call pending.
// - Writing one to bit 27 clears service-call.
// - Writing one to bit 26 sets tick.
// - Bit 26 reads tick pending state.
// - Writing one to bit 25 clears tick.
// - Bit 25 read value is not defined.
// - Bit 22 flags pending interrupts, excluding faults.
// - Bits 17:12 give highest pending enabled number.
// - That field reads zero when nothing pending.
// - Bits 5:0 give active number, zero thread.
// - Active number equals status field bits 5:0.
// - Bit 28 reads service-call pending state.
`timescale 1ns/100ps
module ecs_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic                CLK_I,
  input  wire logic                RESET_I,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0]   AWADDR_I,
  input  wire logic                AWVALID_I,
  output logic                     AWREADY_O,
  input  wire logic [31:0]         WDATA_I,
  input  wire logic [3:0]          WSTRB_I,
  input  wire logic                WVALID_I,
  output logic                     WREADY_O,
  // AXI4-Lite write response
  output logic [1:0]               BRESP_O,
  output logic                     BVALID_O,
  input  wire logic                BREADY_I,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0]   ARADDR_I,
  input  wire logic                ARVALID_I,
  output logic                     ARREADY_O,
  output logic [31:0]              RDATA_O,
  output logic [1:0]               RRESP_O,
  output logic                     RVALID_O,
  input  wire logic                RREADY_I,
  // Core side
  input  wire ecs_pkg::ecs_core_t  CORE_I,
  input  wire ecs_pkg::ecs_hw_t    HW_I,
  output logic                     SERVICE_CALL_PENDING_O,
  output logic                     TICK_PENDING_O,
  // Interrupt
  output logic                     IRQ_O
);

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              aw_got;
  logic              w_got;
  logic              wr_fire;
  logic              wr_ctrl;
  logic              wr_mask;
  logic              wr_known;

  assign wr_fire  = aw_got & w_got;
  assign wr_ctrl  = wr_addr == ADDR_W'(ecs_pkg::ADDR_CTRL);
  assign wr_mask  = wr_addr == ADDR_W'(ecs_pkg::ADDR_MASK);
  assign wr_known = wr_ctrl | wr_mask | (wr_addr == ADDR_W'(ecs_pkg::ADDR_STAT));

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      aw_got    <= 1'b0;
      AWREADY_O <= 1'b0;
      wr_addr   <= '0;
    end
    else if (AWVALID_I && AWREADY_O)
    begin
      aw_got    <= 1'b1;
      AWREADY_O <= 1'b0;
      wr_addr   <= AWADDR_I;
    end
    else if (wr_fire)
    begin
      aw_got <= 1'b0;
    end
    else if (!aw_got && !BVALID_O)
    begin
      AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      w_got    <= 1'b0;
      WREADY_O <= 1'b0;
      wr_data  <= 32'h0000_0000;
      wr_strb  <= 4'h0;
    end
    else if (WVALID_I && WREADY_O)
    begin
      w_got    <= 1'b1;
      WREADY_O <= 1'b0;
      wr_data  <= WDATA_I;
      wr_strb  <= WSTRB_I;
    end
    else if (wr_fire)
    begin
      w_got <= 1'b0;
    end
    else if (!w_got && !BVALID_O)
    begin
      WREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      BVALID_O <= 1'b0;
      BRESP_O  <= ecs_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      BVALID_O <= 1'b1;
      BRESP_O  <= wr_known ? ecs_pkg::RESP_OKAY : ecs_pkg::RESP_SLVERR;
    end
    else if (BVALID_O && BREADY_I)
    begin
      BVALID_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  logic cmd_wr;
  logic svc_set;
  logic svc_clr;
  logic tick_set;
  logic tick_clr;

  // Only the top byte lane carries the set and clear commands
  assign cmd_wr   = wr_fire & wr_ctrl & wr_strb[ecs_pkg::CMD_LANE];
  assign svc_set  = cmd_wr & wr_data[ecs_pkg::SVC_SET_BIT];
  assign svc_clr  = (cmd_wr & wr_data[ecs_pkg::SVC_CLR_BIT]) | HW_I.service_call_taken;
  assign tick_set = (cmd_wr & wr_data[ecs_pkg::TICK_SET_BIT]) | HW_I.tick_event;
  assign tick_clr = (cmd_wr & wr_data[ecs_pkg::TICK_CLR_BIT]) | HW_I.tick_taken;

  // Simultaneous set and clear leaves the flag pending
  ecs_pend_bit u_svc_pend (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .set_i   (svc_set),
    .clr_i   (svc_clr),
    .pend_o  (SERVICE_CALL_PENDING_O)
  );

  ecs_pend_bit u_tick_pend (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .set_i   (tick_set),
    .clr_i   (tick_clr),
    .pend_o  (TICK_PENDING_O)
  );

  // ----------------------------------------------------------------
  // Event status and mask
  // ----------------------------------------------------------------
  logic [ecs_pkg::N_EVT-1:0] evt_mask;
  logic [ecs_pkg::N_EVT-1:0] evt_status;
  logic [ecs_pkg::N_EVT-1:0] evt_set;
  logic [ecs_pkg::N_EVT-1:0] evt_clr;
  logic                      svc_q;
  logic                      tick_q;
  logic                      any_q;

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      svc_q  <= 1'b0;
      tick_q <= 1'b0;
      any_q  <= 1'b0;
    end
    else
    begin
      svc_q  <= SERVICE_CALL_PENDING_O;
      tick_q <= TICK_PENDING_O;
      any_q  <= CORE_I.any_interrupt_pending;
    end
  end

  always_comb
  begin
    evt_set                    = '0;
    evt_set[ecs_pkg::EVT_SVC]  = SERVICE_CALL_PENDING_O & ~svc_q;
    evt_set[ecs_pkg::EVT_TICK] = TICK_PENDING_O & ~tick_q;
    evt_set[ecs_pkg::EVT_ANY]  = CORE_I.any_interrupt_pending & ~any_q;
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      evt_mask <= ecs_pkg::MASK_RST;
    end
    else if (wr_fire && wr_mask && wr_strb[0])
    begin
      evt_mask <= wr_data[ecs_pkg::N_EVT-1:0];
    end
  end

  ecs_irq_status #(
    .N (ecs_pkg::N_EVT)
  ) u_irq (
    .clk_i    (CLK_I),
    .reset_i  (RESET_I),
    .set_i    (evt_set),
    .clr_i    (evt_clr),
    .mask_i   (evt_mask),
    .status_o (evt_status),
    .irq_o    (IRQ_O)
  );

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic        ar_fire;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign ar_fire = ARVALID_I & ARREADY_O;
  // A taken status read clears exactly the bits it returns
  assign evt_clr = (ar_fire && ARADDR_I == ADDR_W'(ecs_pkg::ADDR_STAT)) ? evt_status : '0;

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    next_rresp = ecs_pkg::RESP_OKAY;
    if (ARADDR_I == ADDR_W'(ecs_pkg::ADDR_CTRL))
    begin
      next_rdata[ecs_pkg::SVC_SET_BIT]  = SERVICE_CALL_PENDING_O;
      next_rdata[ecs_pkg::TICK_SET_BIT] = TICK_PENDING_O;
      next_rdata[ecs_pkg::ANY_PEND_BIT] = CORE_I.any_interrupt_pending;
      if (CORE_I.highest_valid)
      begin
        next_rdata[ecs_pkg::HIGH_LSB +: ecs_pkg::NUM_W] = CORE_I.highest_pending_number;
      end
      next_rdata[ecs_pkg::ACT_LSB +: ecs_pkg::NUM_W] =
        CORE_I.program_status_exception_field[5:0];
    end
    else if (ARADDR_I == ADDR_W'(ecs_pkg::ADDR_STAT))
    begin
      next_rdata[ecs_pkg::N_EVT-1:0] = evt_status;
    end
    else if (ARADDR_I == ADDR_W'(ecs_pkg::ADDR_MASK))
    begin
      next_rdata[ecs_pkg::N_EVT-1:0] = evt_mask;
    end
    else
    begin
      next_rresp = ecs_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge CLK_I)
  begin
    if (RESET_I)
    begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h0000_0000;
      RRESP_O   <= ecs_pkg::RESP_OKAY;
    end
    else if (ar_fire)
    begin
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b1;
      RDATA_O   <= next_rdata;
      RRESP_O   <= next_rresp;
    end
    else if (RVALID_O && RREADY_I)
    begin
      RVALID_O <= 1'b0;
    end
    else if (!RVALID_O)
    begin
      ARREADY_O <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  svc_only_sw_a: assert property (
    $rose(SERVICE_CALL_PENDING_O) |-> $past(cmd_wr && wr_data[ecs_pkg::SVC_SET_BIT]))
    else $error("service call became pending without a software set");

  svc_clear_a: assert property (
    cmd_wr && wr_data[ecs_pkg::SVC_CLR_BIT] && !wr_data[ecs_pkg::SVC_SET_BIT] |=> !SERVICE_CALL_PENDING_O)
    else $error("service call clear did not remove pending");

  tick_set_a: assert property (
    cmd_wr && wr_data[ecs_pkg::TICK_SET_BIT] |=> TICK_PENDING_O)
    else $error("tick set did not make tick pending");

  tick_clear_a: assert property (
    cmd_wr && wr_data[ecs_pkg::TICK_CLR_BIT] && !wr_data[ecs_pkg::TICK_SET_BIT] && !HW_I.tick_event
    |=> !TICK_PENDING_O)
    else $error("tick clear did not remove pending");

  pend_readback_a: assert property (
    ar_fire && ARADDR_I == ADDR_W'(ecs_pkg::ADDR_CTRL)
    |=> RDATA_O[ecs_pkg::TICK_SET_BIT] == $past(TICK_PENDING_O)
        && RDATA_O[ecs_pkg::SVC_SET_BIT] == $past(SERVICE_CALL_PENDING_O))
    else $error("pending bits read back wrong");

  numbers_read_a: assert property (
    ar_fire && ARADDR_I == ADDR_W'(ecs_pkg::ADDR_CTRL)
    |=> RDATA_O[17:12] == ($past(CORE_I.highest_valid) ? $past(CORE_I.highest_pending_number) : 6'h00)
        && RDATA_O[5:0] == $past(CORE_I.program_status_exception_field[5:0])
        && RDATA_O[22] == $past(CORE_I.any_interrupt_pending))
    else $error("reported numbers or pending flag wrong");

  reserved_zero_a: assert property (
    $rose(RVALID_O) && RRESP_O == ecs_pkg::RESP_OKAY
    |-> RDATA_O[31:29] == 3'h0 && RDATA_O[25:23] == 3'h0 && RDATA_O[21:18] == 4'h0
        && RDATA_O[11:6] == 6'h00)
    else $error("reserved bits read nonzero");

  irq_level_a: assert property (
    ##1 IRQ_O == $past(|(evt_status & evt_mask)))
    else $error("interrupt output does not follow masked status");

  write_resp_a: assert property (
    wr_fire |=> BVALID_O)
    else $error("write response missing");

endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench for the exception control and state block
// Assumes: AXI4-Lite master tasks, one 10 MHz clock, synchronous reset
// Notes:   Bit 25 is masked out of control reads, its read value is not defined
`timescale 1ns/100ps
module testbench;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              CLK_I, RESET_I;
  logic [7:0]        AWADDR_I, ARADDR_I;
  logic              AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I;
  logic [31:0]       WDATA_I;
  logic [3:0]        WSTRB_I;
  logic              AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic [1:0]        BRESP_O, RRESP_O;
  logic [31:0]       RDATA_O;
  ecs_pkg::ecs_core_t CORE_I;
  ecs_pkg::ecs_hw_t   HW_I;
  logic              SERVICE_CALL_PENDING_O, TICK_PENDING_O, IRQ_O;
  int                fail_count, n_checks;
  logic              svc, tick;
  logic [31:0]       d;
  logic [1:0]        r;
  ecs_pkg::ecs_core_t tbl [4];

  ecs_top dut_u (.CLK_I(CLK_I), .RESET_I(RESET_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .CORE_I(CORE_I), .HW_I(HW_I),
    .SERVICE_CALL_PENDING_O(SERVICE_CALL_PENDING_O), .TICK_PENDING_O(TICK_PENDING_O), .IRQ_O(IRQ_O));

  initial
  begin
    CLK_I = 1'b0;
    forever #50 CLK_I = ~CLK_I;
  end

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dat, input logic [3:0] s);
    logic aw, w;
    @(posedge CLK_I);
    AWADDR_I  <= a;
    AWVALID_I <= 1'b1;
    WDATA_I   <= dat;
    WSTRB_I   <= s;
    WVALID_I  <= 1'b1;
    BREADY_I  <= 1'b1;
    aw = 1'b1;
    w  = 1'b1;
    do
    begin
      @(posedge CLK_I);
      if (aw && AWREADY_O)
      begin
        aw = 1'b0;
        AWVALID_I <= 1'b0;
      end
      if (w && WREADY_O)
      begin
        w = 1'b0;
        WVALID_I <= 1'b0;
      end
    end while (BVALID_O !== 1'b1);
    BREADY_I <= 1'b0;
    r = BRESP_O;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge CLK_I);
    ARADDR_I  <= a;
    ARVALID_I <= 1'b1;
    RREADY_I  <= 1'b1;
    do
    begin
      @(posedge CLK_I);
      if (ARREADY_O === 1'b1)
        ARVALID_I <= 1'b0;
    end while (RVALID_O !== 1'b1);
    RREADY_I <= 1'b0;
    d = RDATA_O;
    r = RRESP_O;
  endtask

  function automatic logic [31:0] exp_ctrl(input ecs_pkg::ecs_core_t c);
    exp_ctrl = 32'h0;
    exp_ctrl[28] = svc;
    exp_ctrl[26] = tick;
    exp_ctrl[22] = c.any_interrupt_pending;
    if (c.highest_valid)
      exp_ctrl[17:12] = c.highest_pending_number;
    exp_ctrl[5:0] = c.program_status_exception_field[5:0];
  endfunction

  // Control read plus the pending outputs
  task automatic chk_ctrl();
    rd(ecs_pkg::ADDR_CTRL);
    chk(d & 32'hFDFF_FFFF, exp_ctrl(CORE_I));
    chk({30'h0, SERVICE_CALL_PENDING_O, TICK_PENDING_O}, {30'h0, svc, tick});
  endtask

  task automatic pulse(input ecs_pkg::ecs_hw_t p);
    @(posedge CLK_I);
    HW_I <= p;
    @(posedge CLK_I);
    HW_I <= 3'h0;
    repeat (2) @(posedge CLK_I);
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge CLK_I);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial
  begin
    RESET_I = 1'b1;
    {AWADDR_I, ARADDR_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
    WDATA_I = 32'h0;
    WSTRB_I = 4'h0;
    CORE_I = '0;
    HW_I = '0;
    fail_count = 0;
    n_checks = 0;
    svc = 1'b0;
    tick = 1'b0;
    tbl[0] = {1'b1, 1'b1, 6'h0F, 9'h1F3};
    tbl[1] = {1'b0, 1'b0, 6'h2A, 9'h000};
    tbl[2] = {1'b1, 1'b1, 6'h3F, 9'h03F};
    tbl[3] = {1'b0, 1'b1, 6'h01, 9'h110};
    repeat (16) @(posedge CLK_I);
    RESET_I <= 1'b0;
    repeat (2) @(posedge CLK_I);
    chk_ctrl();
    rd(ecs_pkg::ADDR_MASK);
    chk(d, 32'h0);
    $display("test reset done");
    wr(ecs_pkg::ADDR_CTRL, 32'h0, 4'hF);
    chk_ctrl();
    wr(ecs_pkg::ADDR_CTRL, 32'h1000_0000, 4'hF);
    svc = 1'b1;
    chk({30'h0, r}, {30'h0, ecs_pkg::RESP_OKAY});
    chk_ctrl();
    wr(ecs_pkg::ADDR_CTRL, 32'h0400_0000, 4'hF);
    tick = 1'b1;
    chk_ctrl();
    wr(ecs_pkg::ADDR_CTRL, 32'hE1FF_FFFF, 4'hF);
    chk_ctrl();
    wr(ecs_pkg::ADDR_CTRL, 32'h0800_0000, 4'hF);
    svc = 1'b0;
    chk_ctrl();
    wr(ecs_pkg::ADDR_CTRL, 32'h0200_0000, 4'hF);
    tick = 1'b0;
    chk_ctrl();
    $display("test set clear done");
    pulse(3'h4);
    tick = 1'b1;
    chk_ctrl();
    pulse(3'h1);
    tick = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(posedge CLK_I);
      CORE_I <= tbl[i];
      @(posedge CLK_I);
      chk_ctrl();
    end
    wr(ecs_pkg::ADDR_CTRL, 32'h1000_0000, 4'hF);
    svc = 1'b1;
    pulse(3'h2);
    svc = 1'b0;
    chk_ctrl();
    $display("test core fields done");
    @(posedge CLK_I);
    CORE_I <= '0;
    rd(ecs_pkg::ADDR_STAT);
    wr(ecs_pkg::ADDR_MASK, 32'h0000_0007, 4'h1);
    rd(ecs_pkg::ADDR_MASK);
    chk(d, 32'h0000_0007);
    rd(ecs_pkg::ADDR_STAT);
    chk(d, 32'h0);
    wr(ecs_pkg::ADDR_CTRL, 32'h1000_0000, 4'h7);
    chk_ctrl();
    wr(ecs_pkg::ADDR_CTRL, 32'h1000_0000, 4'h8);
    svc = 1'b1;
    repeat (3) @(posedge CLK_I);
    chk({31'h0, IRQ_O}, 32'h1);
    rd(ecs_pkg::ADDR_STAT);
    chk(d, 32'h1);
    repeat (3) @(posedge CLK_I);
    chk({31'h0, IRQ_O}, 32'h0);
    rd(ecs_pkg::ADDR_STAT);
    chk(d, 32'h0);
    wr(ecs_pkg::ADDR_MASK, 32'h0000_0004, 4'h1);
    wr(ecs_pkg::ADDR_CTRL, 32'h0400_0000, 4'h8);
    tick = 1'b1;
    repeat (3) @(posedge CLK_I);
    chk({31'h0, IRQ_O}, 32'h0);
    @(posedge CLK_I);
    CORE_I <= tbl[0];
    repeat (3) @(posedge CLK_I);
    chk({31'h0, IRQ_O}, 32'h1);
    rd(ecs_pkg::ADDR_STAT);
    chk(d, 32'h6);
    chk_ctrl();
    chk({26'h0, d[5:0]} - 32'h0000_0010, 32'h0000_0023);
    $display("test interrupt done");
    wr(8'h0C, 32'h1000_0000, 4'hF);
    chk({30'h0, r}, {30'h0, ecs_pkg::RESP_SLVERR});
    rd(8'h0C);
    chk({30'h0, r}, {30'h0, ecs_pkg::RESP_SLVERR});
    chk(d, 32'h0);
    rd(ecs_pkg::ADDR_CTRL);
    chk({30'h0, r}, {30'h0, ecs_pkg::RESP_OKAY});
    chk_ctrl();
    $display("test unmapped done");
    give_verdict();
  end
endmodule
